// [verilog/cstr_pkg.sv]
// Constants shared by the card synchronisation timing router.
// Assumes a 32-bit plain register port with byte addresses on word boundaries.
package cstr_pkg;

	// =====================================================================
	// Channel layout
	// =====================================================================
	localparam int CSTR_NCH = 6;
	localparam int CSTR_CH_CLOCK = 0;
	localparam int CSTR_CH_ACQ = 1;
	localparam int CSTR_CH_CONV = 2;
	localparam int CSTR_CH_SCAN = 3;
	localparam int CSTR_CH_WAVE = 4;
	localparam int CSTR_CH_UPD = 5;

	// Six bus lines, the external clock input and the on-card oscillator.
	localparam int CSTR_SYNC_W = 8;
	localparam int CSTR_SYNC_EXT = 6;
	localparam int CSTR_SYNC_OSC = 7;

	// =====================================================================
	// Register map
	// =====================================================================
	localparam int CSTR_AW = 8;
	localparam int CSTR_DW = 32;
	localparam logic [7:0] CSTR_ADDR_ROLE = 8'h00;
	localparam logic [7:0] CSTR_ADDR_CLKSRC = 8'h04;
	localparam logic [7:0] CSTR_ADDR_STATUS = 8'h08;

	localparam int CSTR_ROLE_FW = 2;
	localparam int CSTR_ROLE_W = CSTR_NCH * CSTR_ROLE_FW;
	localparam int CSTR_CLKSRC_W = 2;
	localparam int CSTR_STAT_LVL_LSB = 0;
	localparam int CSTR_STAT_OE_LSB = 8;
	localparam int CSTR_STAT_CLK_LSB = 16;

	localparam logic [11:0] CSTR_ROLE_RST = 12'h000;
	localparam logic [1:0] CSTR_CLKSRC_RST = 2'h0;

	// =====================================================================
	// Encodings
	// =====================================================================
	typedef enum logic [1:0] {
		CSTR_ROLE_OFF = 2'h0,
		CSTR_ROLE_MASTER = 2'h1,
		CSTR_ROLE_SLAVE = 2'h2
	} cstr_role_t;

	typedef enum logic [1:0] {
		CSTR_CLK_INTERNAL = 2'h0,
		CSTR_CLK_EXTERNAL = 2'h1,
		CSTR_CLK_BUS = 2'h2
	} cstr_clksrc_t;

endpackage : cstr_pkg

// [verilog/cstr_sync2.sv]
// Two-flop level synchroniser for a vector of unrelated inputs.
// Assumes each bit is an independent level; no bit relation is kept.
`timescale 1ns/1ps
module cstr_sync2
	import cstr_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [CSTR_SYNC_W-1:0] async_in,
	output logic [CSTR_SYNC_W-1:0] sync_out
);

	// =====================================================================
	// Synchroniser stages
	// =====================================================================
	logic [CSTR_SYNC_W-1:0] meta_reg;
	logic [CSTR_SYNC_W-1:0] sync_reg;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;

endmodule : cstr_sync2

// [verilog/cstr_router.sv]
// Card synchronisation timing router: six timing signals to and from the bus.
// Assumes internal timing strobes arrive on mclk; bus lines and clocks are foreign.
// Operation
// [R1] A bus line is driven by exactly one card and read by at most three others.
// [R2] The shared clock is driven out as master and replaces the card clock as slave.
// [R3] The acquisition trigger is driven out as master and used as trigger as slave.
// [R4] The convert strobe is driven out as master and replaces the local one as slave.
// [R5] The scan begin pulse is driven out as master and replaces the local one as slave.
// [R6] The wave trigger is driven out as master and used as trigger as slave.
// [R7] The update strobe is driven out as master and replaces the local one as slave.
// [R8] Software selects a routing path for each of the six timing signals.
// [R9] System setup gives each signal one master, the others slave or off.
// [R10] Each signal holds its own role, so masters may sit on different cards.
// [R11] After reset every signal uses its internal source and no bus line is used.
// [R12] A bus line is driven only in master role and left undriven otherwise.
// [R13] The card clock comes from the oscillator, the external input or the bus.
`timescale 1ns/1ps
module cstr_router
	import cstr_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [CSTR_AW-1:0] reg_addr,
	input wire logic [CSTR_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [CSTR_DW-1:0] reg_rdata,
	input wire logic osc_clock,
	input wire logic external_clock_input,
	input wire logic int_acq_trigger,
	input wire logic int_convert_strobe,
	input wire logic int_scan_begin,
	input wire logic int_wave_trigger,
	input wire logic int_update_strobe,
	input wire logic bus_shared_clock_i,
	output logic bus_shared_clock_o,
	output logic bus_shared_clock_oe,
	input wire logic bus_acq_trigger_i,
	output logic bus_acq_trigger_o,
	output logic bus_acq_trigger_oe,
	input wire logic bus_convert_strobe_i,
	output logic bus_convert_strobe_o,
	output logic bus_convert_strobe_oe,
	input wire logic bus_scan_begin_i,
	output logic bus_scan_begin_o,
	output logic bus_scan_begin_oe,
	input wire logic bus_wave_trigger_i,
	output logic bus_wave_trigger_o,
	output logic bus_wave_trigger_oe,
	input wire logic bus_update_strobe_i,
	output logic bus_update_strobe_o,
	output logic bus_update_strobe_oe,
	output logic card_clock,
	output logic acq_trigger,
	output logic convert_strobe,
	output logic scan_begin,
	output logic wave_trigger,
	output logic output_update_strobe
);

	// =====================================================================
	// Input synchronisation
	// =====================================================================
	logic [CSTR_SYNC_W-1:0] raw_in;
	logic [CSTR_SYNC_W-1:0] sync_in;
	logic [CSTR_NCH-1:0] bus_s;
	logic ext_s;
	logic osc_s;

	assign raw_in = {osc_clock, external_clock_input,
		bus_update_strobe_i, bus_wave_trigger_i, bus_scan_begin_i,
		bus_convert_strobe_i, bus_acq_trigger_i, bus_shared_clock_i};

	cstr_sync2 u_sync (
		.mclk(mclk),
		.reset(reset),
		.async_in(raw_in),
		.sync_out(sync_in)
	);

	assign bus_s = sync_in[CSTR_NCH-1:0];
	assign ext_s = sync_in[CSTR_SYNC_EXT];
	assign osc_s = sync_in[CSTR_SYNC_OSC];

	// =====================================================================
	// Configuration registers
	// =====================================================================
	logic [CSTR_ROLE_W-1:0] role_reg;
	logic [CSTR_ROLE_W-1:0] role_next;
	logic [CSTR_CLKSRC_W-1:0] clksrc_reg;
	logic [CSTR_CLKSRC_W-1:0] clksrc_next;
	logic [CSTR_DW-1:0] rdata_reg;
	logic [CSTR_DW-1:0] rdata_next;
	logic [CSTR_NCH-1:0] drive_reg;
	logic [CSTR_NCH-1:0] line_reg;
	logic [CSTR_NCH-1:0] sel_reg;

	always_comb begin
		role_next = role_reg;
		clksrc_next = clksrc_reg;
		rdata_next = '0;
		// [R8] per-signal path select
		if (reg_wr && reg_addr == CSTR_ADDR_ROLE) begin
			role_next = reg_wdata[CSTR_ROLE_W-1:0];
		end
		// [R13] clock source select
		if (reg_wr && reg_addr == CSTR_ADDR_CLKSRC) begin
			clksrc_next = reg_wdata[CSTR_CLKSRC_W-1:0];
		end
		if (reg_rd) begin
			case (reg_addr)
				CSTR_ADDR_ROLE: begin
					rdata_next[CSTR_ROLE_W-1:0] = role_reg;
				end
				CSTR_ADDR_CLKSRC: begin
					rdata_next[CSTR_CLKSRC_W-1:0] = clksrc_reg;
				end
				CSTR_ADDR_STATUS: begin
					rdata_next[CSTR_STAT_LVL_LSB +: CSTR_NCH] = bus_s;
					rdata_next[CSTR_STAT_OE_LSB +: CSTR_NCH] = drive_reg;
					rdata_next[CSTR_STAT_CLK_LSB] = sel_reg[CSTR_CH_CLOCK];
				end
				default: begin
					rdata_next = '0;
				end
			endcase
		end
	end

	// [R11] internal sources after reset
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			role_reg <= CSTR_ROLE_RST;
			clksrc_reg <= CSTR_CLKSRC_RST;
			rdata_reg <= '0;
		end else begin
			role_reg <= role_next;
			clksrc_reg <= clksrc_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

	// =====================================================================
	// Role decode and routing
	// =====================================================================
	logic [CSTR_NCH-1:0] master_vec;
	logic [CSTR_NCH-1:0] slave_vec;
	logic [CSTR_NCH-1:0] local_src;
	logic [CSTR_NCH-1:0] drive_next;
	logic [CSTR_NCH-1:0] line_next;
	logic [CSTR_NCH-1:0] sel_next;
	logic local_clock;

	// An undefined role code behaves as off, so a bad write never drives a line.
	// [R10] independent role per signal
	genvar gi;
	generate
		for (gi = 0; gi < CSTR_NCH; gi++) begin : g_role
			assign master_vec[gi] =
				(role_reg[gi*CSTR_ROLE_FW +: CSTR_ROLE_FW] == CSTR_ROLE_MASTER);
			assign slave_vec[gi] =
				(role_reg[gi*CSTR_ROLE_FW +: CSTR_ROLE_FW] == CSTR_ROLE_SLAVE);
		end
	endgenerate

	// [R13] oscillator or external clock
	always_comb begin
		local_clock = osc_s;
		if (clksrc_reg == CSTR_CLK_EXTERNAL) begin
			local_clock = ext_s;
		end
	end

	// The master sends its own chosen clock, never one it received back.
	assign local_src = {int_update_strobe, int_wave_trigger, int_scan_begin,
		int_convert_strobe, int_acq_trigger, local_clock};

	always_comb begin
		drive_next = '0;
		line_next = '0;
		sel_next = local_src;
		for (int i = 0; i < CSTR_NCH; i++) begin
			// [R12] drive only as master
			if (master_vec[i]) begin
				drive_next[i] = 1'b1;
				line_next[i] = local_src[i];
			end
			// [R3] [R4] [R5] [R6] [R7] slave takes bus
			if (slave_vec[i]) begin
				sel_next[i] = bus_s[i];
			end
		end
		// [R2] bus clock replaces card clock
		if (clksrc_reg == CSTR_CLK_BUS && !master_vec[CSTR_CH_CLOCK]) begin
			sel_next[CSTR_CH_CLOCK] = bus_s[CSTR_CH_CLOCK];
		end
	end

	// [R1] one driver per line
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			drive_reg <= '0;
			line_reg <= '0;
			sel_reg <= '0;
		end else begin
			drive_reg <= drive_next;
			line_reg <= line_next;
			sel_reg <= sel_next;
		end
	end

	// =====================================================================
	// Output mapping
	// =====================================================================
	assign bus_shared_clock_o = line_reg[CSTR_CH_CLOCK];
	assign bus_shared_clock_oe = drive_reg[CSTR_CH_CLOCK];
	assign bus_acq_trigger_o = line_reg[CSTR_CH_ACQ];
	assign bus_acq_trigger_oe = drive_reg[CSTR_CH_ACQ];
	assign bus_convert_strobe_o = line_reg[CSTR_CH_CONV];
	assign bus_convert_strobe_oe = drive_reg[CSTR_CH_CONV];
	assign bus_scan_begin_o = line_reg[CSTR_CH_SCAN];
	assign bus_scan_begin_oe = drive_reg[CSTR_CH_SCAN];
	assign bus_wave_trigger_o = line_reg[CSTR_CH_WAVE];
	assign bus_wave_trigger_oe = drive_reg[CSTR_CH_WAVE];
	assign bus_update_strobe_o = line_reg[CSTR_CH_UPD];
	assign bus_update_strobe_oe = drive_reg[CSTR_CH_UPD];
	assign card_clock = sel_reg[CSTR_CH_CLOCK];
	assign acq_trigger = sel_reg[CSTR_CH_ACQ];
	assign convert_strobe = sel_reg[CSTR_CH_CONV];
	assign scan_begin = sel_reg[CSTR_CH_SCAN];
	assign wave_trigger = sel_reg[CSTR_CH_WAVE];
	assign output_update_strobe = sel_reg[CSTR_CH_UPD];

	// =====================================================================
	// Assertions
	// =====================================================================
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	AST_ROLE_WRITE: assert property ( // [R8]
		reg_wr && reg_addr == CSTR_ADDR_ROLE |=> role_reg == $past(reg_wdata[11:0])
	) else $error("Role register did not take the written value.");

	AST_OFF_IS_QUIET: assert property ( // [R12]
		(drive_reg & ~$past(master_vec)) == 6'h00
	) else $error("A bus line is driven without master role.");

	AST_CLOCK_SLAVE: assert property ( // [R2]
		(slave_vec[0] && bus_shared_clock_i)[*4] |-> card_clock
	) else $error("Slave card clock does not follow the bus clock.");

	AST_ACQ_SLAVE: assert property ( // [R3]
		(slave_vec[1] && bus_acq_trigger_i)[*4] |-> acq_trigger
	) else $error("Slave acquisition trigger does not follow the bus.");

	AST_CONV_SLAVE: assert property ( // [R4]
		(slave_vec[2] && !bus_convert_strobe_i)[*4] |-> !convert_strobe
	) else $error("Slave convert strobe does not follow the bus.");

	AST_SCAN_MASTER: assert property ( // [R5]
		master_vec[3] && int_scan_begin |=> bus_scan_begin_oe && bus_scan_begin_o
	) else $error("Master scan begin is not driven onto the bus.");

	AST_WAVE_OFF: assert property ( // [R6]
		role_reg[9:8] == 2'h0 |=> !bus_wave_trigger_oe &&
			wave_trigger == $past(int_wave_trigger)
	) else $error("Disabled wave trigger is not local or drives the bus.");

	AST_UPD_SLAVE: assert property ( // [R7]
		slave_vec[5] |=> !bus_update_strobe_oe ##0
			output_update_strobe == $past(bus_s[5])
	) else $error("Slave update strobe drives the bus or is not taken.");

	AST_EXT_CLOCK: assert property ( // [R13]
		(clksrc_reg == 2'h1 && !slave_vec[0] && !external_clock_input)[*4] |-> !card_clock
	) else $error("External clock selection is not honoured.");

	AST_RESET_LOCAL: assert property ( // [R11]
		role_reg == 12'h000 && clksrc_reg == 2'h0 |=> drive_reg == 6'h00 &&
			acq_trigger == $past(int_acq_trigger)
	) else $error("Default configuration is not purely internal.");

	AST_RESET_DEFAULT: assert property ( // [R11]
		$fell(reset) |-> role_reg == CSTR_ROLE_RST && clksrc_reg == CSTR_CLKSRC_RST &&
			drive_reg == 6'h00
	) else $error("Configuration is not at its defaults after reset.");

	AST_LINE_LOW: assert property ( // [R12]
		(line_reg & ~drive_reg) == 6'h00
	) else $error("A released bus line carries a high level.");

	// Read data must fall back to zero so a stale word is never mistaken for a fresh one.
	AST_RDATA_IDLE: assert property ( // [R8]
		!$past(reg_rd) |-> reg_rdata == 32'h0000_0000
	) else $error("Read data is not zero outside the read answer cycle.");

	AST_ACQ_MASTER: assert property ( // [R3]
		master_vec[CSTR_CH_ACQ] |=> bus_acq_trigger_oe &&
			bus_acq_trigger_o == $past(int_acq_trigger)
	) else $error("Master acquisition trigger is not driven onto the bus.");

	AST_UPD_MASTER: assert property ( // [R7]
		master_vec[CSTR_CH_UPD] |=> bus_update_strobe_oe &&
			bus_update_strobe_o == $past(int_update_strobe)
	) else $error("Master update strobe is not driven onto the bus.");

	AST_CLOCK_MASTER: assert property ( // [R2]
		master_vec[CSTR_CH_CLOCK] && clksrc_reg == CSTR_CLK_INTERNAL |=>
			bus_shared_clock_oe && bus_shared_clock_o == $past(osc_s)
	) else $error("Master shared clock does not carry the oscillator.");

endmodule : cstr_router

// [verification/cstr_peer_card.sv]
// Peer card router on the far side of the sync bus.
// Assumes the bench resolves each line from the router's enable alone.
`timescale 1ns/1ps
module cstr_peer_card (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [5:0] master,
	input wire logic [5:0] level,
	output logic [5:0] line_o,
	output logic [5:0] line_oe
);
	// ========
	// Lines
	// ========
	logic link_clk;
	logic idle_reg;
	// The shared clock runs at 64 ns only while this card masters it.
	initial begin
		link_clk = 1'b0;
		#5;
		forever #32 link_clk = master[0] ? ~link_clk : 1'b0;
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			idle_reg <= 1'b0;
		end else begin
			idle_reg <= ~idle_reg;
		end
	end
	// single master per line
	// A released line toggles so that a stale level is never mistaken for data.
	always_comb begin
		line_oe = master;
		line_o = (master & level) | (~master & {6{idle_reg}});
		line_o[0] = master[0] ? link_clk : idle_reg;
	end
endmodule : cstr_peer_card

// [verification/cstr_router_bench.sv]
// Self-checking bench for the timing router facing one peer card.
// Assumes the peer model is compiled first.
`timescale 1ns/1ps
module cstr_router_bench
	import cstr_pkg::*;
;
	logic mclk, reset, reg_wr, reg_rd, osc_clock, ext_in;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic [5:0] int_src, peer_m, peer_lvl;
	wire [5:0] peer_o, peer_oe, dut_o, dut_oe, sel, line;
	int err_count, compares, cycles;
	assign line = (dut_oe & dut_o) | (~dut_oe & peer_o);
	cstr_peer_card peer_u (.mclk(mclk), .reset(reset), .master(peer_m), .level(peer_lvl),
		.line_o(peer_o), .line_oe(peer_oe));
	cstr_router dut_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.osc_clock(osc_clock), .external_clock_input(ext_in),
		.int_acq_trigger(int_src[1]), .int_convert_strobe(int_src[2]),
		.int_scan_begin(int_src[3]), .int_wave_trigger(int_src[4]),
		.int_update_strobe(int_src[5]),
		.bus_shared_clock_i(line[0]), .bus_shared_clock_o(dut_o[0]),
		.bus_shared_clock_oe(dut_oe[0]), .bus_acq_trigger_i(line[1]),
		.bus_acq_trigger_o(dut_o[1]), .bus_acq_trigger_oe(dut_oe[1]),
		.bus_convert_strobe_i(line[2]), .bus_convert_strobe_o(dut_o[2]),
		.bus_convert_strobe_oe(dut_oe[2]), .bus_scan_begin_i(line[3]),
		.bus_scan_begin_o(dut_o[3]), .bus_scan_begin_oe(dut_oe[3]),
		.bus_wave_trigger_i(line[4]), .bus_wave_trigger_o(dut_o[4]),
		.bus_wave_trigger_oe(dut_oe[4]), .bus_update_strobe_i(line[5]),
		.bus_update_strobe_o(dut_o[5]), .bus_update_strobe_oe(dut_oe[5]),
		.card_clock(sel[0]), .acq_trigger(sel[1]), .convert_strobe(sel[2]),
		.scan_begin(sel[3]), .wave_trigger(sel[4]), .output_update_strobe(sel[5]));
	// ========
	// Clock and guard
	// ========
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// Contention is looked at mid-cycle, where both enables have settled.
	always @(negedge mclk) begin
		if ((dut_oe & peer_oe) != 6'h00) begin
			chk(32'(dut_oe & peer_oe), 32'h0);
		end
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			summarize();
		end
	end
	// ========
	// Tasks
	// ========
	task automatic summarize();
		$display("errors=%0d compares=%0d", err_count, compares);
		if (err_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_n(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : wait_n
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rd
	task automatic drive(input logic [5:0] i, input logic o, input logic e);
		@(posedge mclk);
		int_src <= i;
		osc_clock <= o;
		ext_in <= e;
	endtask : drive
	task automatic peer(input logic [5:0] m, input logic [5:0] l);
		@(posedge mclk);
		peer_m <= m;
		peer_lvl <= l;
	endtask : peer
	task automatic clk_edges();
		int c;
		logic p;
		c = 0;
		p = sel[0];
		repeat (64) begin
			@(posedge mclk);
			#1;
			if (sel[0] && !p) c++;
			p = sel[0];
		end
		chk(32'(c >= 7 && c <= 9), 32'h1);
	endtask : clk_edges
	// ========
	// Scenarios
	// ========
	initial begin
		{reset, reg_wr, reg_rd, osc_clock, ext_in} = 5'h10;
		{reg_addr, reg_wdata} = '0;
		{int_src, peer_m, peer_lvl} = '0;
		{err_count, compares, cycles} = '0;
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		rd(CSTR_ADDR_ROLE, 32'h0);
		rd(CSTR_ADDR_CLKSRC, 32'h0);
		drive(6'h3E, 1'b1, 1'b0);
		wait_n(4);
		chk(32'({dut_oe, sel}), 32'h03F);
		for (int n = 0; n < 6; n++) begin
			wr(CSTR_ADDR_ROLE, 32'h1 << (2 * n));
			wait_n(1);
			chk(32'({dut_oe, dut_o}), 32'({2{6'h1 << n}}));
		end
		wr(CSTR_ADDR_ROLE, 32'h555);
		wait_n(4);
		rd(CSTR_ADDR_STATUS, 32'h0001_3F3F);
		wait_n(1);
		chk(reg_rdata, 32'h0);
		drive(6'h00, 1'b0, 1'b0);
		wait_n(1);
		chk(32'(dut_o[5:1]), 32'h0);
		wr(CSTR_ADDR_ROLE, 32'hFFFF_FFFF);
		wr(8'h0C, 32'hFFFF_FFFF);
		rd(8'h0C, 32'h0);
		rd(CSTR_ADDR_ROLE, 32'hFFF);
		chk(32'(dut_oe), 32'h0);
		for (int n = 1; n < 6; n++) begin
			wr(CSTR_ADDR_ROLE, 32'h2 << (2 * n));
			peer(6'h1 << n, 6'h3F);
			wait_n(4);
			chk(32'({dut_oe, sel[n]}), 32'h1);
			peer(6'h1 << n, 6'h00);
			wait_n(2);
			chk(32'(sel[n]), 32'h1);
			wait_n(1);
			chk(32'(sel[n]), 32'h0);
		end
		peer(6'h01, 6'h00);
		wr(CSTR_ADDR_ROLE, 32'h2);
		clk_edges();
		wr(CSTR_ADDR_ROLE, 32'h0);
		wr(CSTR_ADDR_CLKSRC, 32'h2);
		clk_edges();
		peer(6'h00, 6'h00);
		drive(6'h00, 1'b0, 1'b1);
		wr(CSTR_ADDR_CLKSRC, 32'h1);
		wr(CSTR_ADDR_ROLE, 32'h1);
		wait_n(4);
		chk(32'({sel[0], dut_o[0], dut_oe[0]}), 32'h7);
		// Oscillator high and external low tell the two sources apart.
		drive(6'h00, 1'b1, 1'b0);
		wait_n(4);
		chk(32'({sel[0], dut_o[0], dut_oe[0]}), 32'h1);
		wr(CSTR_ADDR_CLKSRC, 32'h0);
		wait_n(4);
		chk(32'({sel[0], dut_o[0], dut_oe[0]}), 32'h7);
		// A reset in mid-run must drop every role the card held.
		wr(CSTR_ADDR_ROLE, 32'h555);
		drive(6'h3E, 1'b1, 1'b0);
		@(posedge mclk);
		reset <= 1'b1;
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		wait_n(1);
		chk(32'({dut_oe, dut_o}), 32'h0);
		wait_n(3);
		chk(32'({dut_oe, sel}), 32'h03F);
		rd(CSTR_ADDR_ROLE, 32'h0);
		summarize();
	end
endmodule : cstr_router_bench
